// ==== hw/prefix_code_decoder.sv ====
// decode-stage prefix handling: data space, register bank, flag freeze, interrupt gate
// assumes fetch gives one classified instruction per issue pulse on core_clk
`timescale 1ns/1ns
`default_nettype none
module prefix_code_decoder (
	input  wire logic                            core_clk,       // 50 MHz core clock
	input  wire logic                            reset_n,        // async reset, low active
	input  wire logic                            issue,          // instruction issued
	input  wire prefix_code_pkg::instr_class_type instrClass,    // its class
	input  wire logic                            resumeString,   // string op resumed after irq
	input  wire logic                            intAccept,      // interrupt accepted
	input  wire logic                            stackFlagWrite, // status write of stack flag
	input  wire logic                            stackFlagData,  // value written
	input  wire logic [4:0]                      regBankPointer, // reg_bank_pointer now
	output prefix_code_pkg::space_type           dataSpace,      // space for data accesses
	output logic [4:0]                           bankPtrUsed,    // effective bank pointer
	output logic                                 flagUpdateEn,   // flags may be written
	output logic                                 intSampleEn,    // irq sampling allowed
	output logic                                 stackSelect,    // stack select flag
	output logic                                 decodeValid     // outputs belong to issue
);
	import prefix_code_pkg::*;

	logic       rstMeta;   // reset synchroniser stage one
	logic       rstN;      // synchronised reset
	logic [1:0] bankQ;     // pending bank choice
	logic       stackPfxQ; // pending stack prefix
	logic       sharedQ;   // pending shared prefix
	logic       freezeQ;   // pending freeze prefix
	logic       isDisable; // one of the ten disable instructions
	logic       isPrefix;  // one of the six prefixes
	logic       consume;   // this instruction uses pending prefixes
	logic       dropPfx;   // resumed string ignores prefixes
	space_type  space_d;   // next data space
	logic [4:0] ptr_d;     // next bank pointer
	logic       flag_d;    // next flag enable

	// reset release through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end

	// classification helpers
	always_comb begin
		isPrefix = (instrClass == CLS_CODE_PFX) || (instrClass == CLS_DATA_PFX) ||
			(instrClass == CLS_EXTRA_PFX) || (instrClass == CLS_STACK_PFX) ||
			(instrClass == CLS_SHARED_PFX) || (instrClass == CLS_FREEZE_PFX);
		// CLS_CCR_LOGIC stands for two of the ten (and, or), so nine classes make up isDisable
		isDisable = isPrefix || (instrClass == CLS_ILM_LOAD) ||
			(instrClass == CLS_CCR_LOGIC) || (instrClass == CLS_STATUS_POP);
		consume = !isDisable;
		// software keeps shared/freeze off strings; a resume drops all anyway
		dropPfx = (instrClass == CLS_STRING) && resumeString;
	end

	prefix_pending pending (
		.clk         (core_clk),
		.rstN        (rstN),
		.issue       (issue),
		.isBankPfx   ((instrClass == CLS_CODE_PFX) || (instrClass == CLS_DATA_PFX) ||
			(instrClass == CLS_EXTRA_PFX)),
		.bankSel     ((instrClass == CLS_CODE_PFX) ? BANK_CODE :
			(instrClass == CLS_DATA_PFX) ? BANK_DATA : BANK_EXTRA),
		.isStackPfx  (instrClass == CLS_STACK_PFX),
		.isSharedPfx (instrClass == CLS_SHARED_PFX),
		.isFreezePfx (instrClass == CLS_FREEZE_PFX),
		.consume     (consume),
		.bankQ       (bankQ),
		.stackQ      (stackPfxQ),
		.sharedQ     (sharedQ),
		.freezeQ     (freezeQ)
	);

	// data space selection for the consuming instruction
	always_comb begin
		space_d = SPACE_DEFAULT;
		case (instrClass)
			CLS_STRING:     space_d = SPACE_OPERAND;
			CLS_STACK_OP,
			CLS_STATUS_POP: space_d = stackSelect ? SPACE_SYS_STACK : SPACE_USER_STACK;
			CLS_IO:         space_d = SPACE_IO;
			CLS_RETURN_INT: space_d = SPACE_SYS_STACK;
			default: begin
				if (consume) begin
					if (stackPfxQ)
						space_d = stackSelect ? SPACE_SYS_STACK : SPACE_USER_STACK;
					else if (bankQ == BANK_CODE)
						space_d = SPACE_CODE;
					else if (bankQ == BANK_DATA)
						space_d = SPACE_DATA;
					else if (bankQ == BANK_EXTRA)
						space_d = SPACE_EXTRA;
				end
			end
		endcase
	end

	// register bank and flag handling
	always_comb begin
		ptr_d  = regBankPointer;
		flag_d = 1'b1;
		if (consume && !dropPfx) begin
			if (sharedQ)
				ptr_d = SHARED_BANK_PTR;
			if (freezeQ)
				flag_d = 1'b0;
		end
		if ((instrClass == CLS_SOFT_INT) || (instrClass == CLS_RETURN_INT) ||
			(instrClass == CLS_CTX_JUMP))
			flag_d = 1'b1;
	end

	// registered decode outputs
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			dataSpace    <= SPACE_DEFAULT;
			bankPtrUsed  <= 5'h00;
			flagUpdateEn <= 1'b1;
			intSampleEn  <= 1'b1;
			decodeValid  <= 1'b0;
		end else begin
			decodeValid <= issue;
			if (issue) begin
				dataSpace    <= space_d;
				bankPtrUsed  <= ptr_d;
				flagUpdateEn <= flag_d;
				intSampleEn  <= !isDisable;
			end
		end
	end

	// stack select flag, set on reset and interrupt acceptance
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN)
			stackSelect <= STACK_SYS;
		else if (intAccept)
			stackSelect <= STACK_SYS;
		else if (stackFlagWrite)
			stackSelect <= stackFlagData;
	end
endmodule // prefix_code_decoder
`default_nettype wire

// ==== hw/prefix_code_pkg.sv ====
// constants and types shared by the prefix-code decoder and its state holder
// assumes the fetch stage presents one decoded instruction class per issue strobe
package prefix_code_pkg;
	// instruction classes delivered by fetch
	typedef enum logic [3:0] {
		CLS_PLAIN,         // ordinary instruction, default space
		CLS_CODE_PFX,      // code_bank_prefix
		CLS_DATA_PFX,      // data_bank_prefix
		CLS_EXTRA_PFX,     // extra_data_bank_prefix
		CLS_STACK_PFX,     // stack_bank_prefix
		CLS_SHARED_PFX,    // shared_reg_bank_prefix
		CLS_FREEZE_PFX,    // flag_freeze_prefix
		CLS_CCR_LOGIC,     // and/or on condition_code_reg
		CLS_ILM_LOAD,      // load of int_level_mask
		CLS_STATUS_POP,    // word_pop of the status word
		CLS_STRING,        // string_move, string_scan, string_fill
		CLS_STACK_OP,      // word_push, word_pop
		CLS_IO,            // io access incl bit_wait_set/bit_wait_clear
		CLS_SOFT_INT,      // soft ints incl far_soft_interrupt
		CLS_RETURN_INT,    // return_from_interrupt
		CLS_CTX_JUMP       // context_jump through accumulator
	} instr_class_type;

	// data space chosen for an instruction's accesses
	typedef enum logic [2:0] {
		SPACE_DEFAULT,     // per addressing mode
		SPACE_CODE,        // code bank
		SPACE_DATA,        // data bank
		SPACE_EXTRA,       // extra data bank
		SPACE_USER_STACK,  // user stack bank
		SPACE_SYS_STACK,   // system_stack_bank
		SPACE_OPERAND,     // bank named by string operand
		SPACE_IO           // io area
	} space_type;

	localparam logic [1:0] BANK_NONE  = 2'h0; // no bank prefix pending
	localparam logic [1:0] BANK_CODE  = 2'h1;
	localparam logic [1:0] BANK_DATA  = 2'h2;
	localparam logic [1:0] BANK_EXTRA = 2'h3;
	localparam logic       STACK_USER = 1'h0; // stack select flag values
	localparam logic       STACK_SYS  = 1'h1;
	localparam logic [4:0] SHARED_BANK_PTR = 5'h00; // bank at 000180H..00018FH
endpackage

// ==== hw/prefix_pending.sv ====
// holds the prefixes collected ahead of the instruction they modify
// assumes issue strobes come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module prefix_pending (
	input  wire logic        clk,         // core clock
	input  wire logic        rstN,        // synchronised reset, low active
	input  wire logic        issue,       // one instruction issued
	input  wire logic        isBankPfx,   // bank prefix issued
	input  wire logic [1:0]  bankSel,     // which bank prefix
	input  wire logic        isStackPfx,  // stack bank prefix issued
	input  wire logic        isSharedPfx, // shared bank prefix issued
	input  wire logic        isFreezePfx, // flag freeze prefix issued
	input  wire logic        consume,     // non-disable instruction used them
	output logic [1:0]       bankQ,       // pending data bank choice
	output logic             stackQ,      // pending stack bank prefix
	output logic             sharedQ,     // pending shared bank prefix
	output logic             freezeQ      // pending flag freeze
);
	import prefix_code_pkg::*;

	// bank-group prefixes overwrite each other, last wins
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			bankQ  <= BANK_NONE;
			stackQ <= 1'b0;
		end else if (issue && consume) begin
			bankQ  <= BANK_NONE;
			stackQ <= 1'b0;
		end else if (issue && isBankPfx) begin
			bankQ  <= bankSel;
			stackQ <= 1'b0;
		end else if (issue && isStackPfx) begin
			bankQ  <= BANK_NONE;
			stackQ <= 1'b1;
		end
	end

	// shared and freeze prefixes do not compete, they accumulate
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sharedQ <= 1'b0;
			freezeQ <= 1'b0;
		end else if (issue && consume) begin
			sharedQ <= 1'b0;
			freezeQ <= 1'b0;
		end else if (issue) begin
			sharedQ <= sharedQ | isSharedPfx;
			freezeQ <= freezeQ | isFreezePfx;
		end
	end
endmodule // prefix_pending
`default_nettype wire

// ==== tb/fetch_model.sv ====
// fetch-side model: offers one classified instruction per issue
// assumes callers enter its tasks just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
	input  wire logic                         clk,          // core clock
	output var prefix_code_pkg::instr_class_type instrClass, // class offered
	output logic                              issue,        // issue strobe
	output logic                              resumeString  // resumed string flag
);
	import prefix_code_pkg::*;
	// quiet at time zero
	initial begin
		issue = 1'h0;
		instrClass = CLS_PLAIN;
		resumeString = 1'h0;
	end
	// strobe stays up between back-to-back issues
	// strings are never offered behind shared or freeze prefixes
	task automatic go(input instr_class_type c);
		issue = 1'h1;
		instrClass = c;
		@(posedge clk);
		#1;
	endtask
	// class is flipped after release so stale values never look valid
	task automatic idle();
		issue = 1'h0;
		instrClass = instr_class_type'(~instrClass);
		@(posedge clk);
		#1;
	endtask
endmodule // fetch_model
`default_nettype wire

// ==== tb/prefix_code_decoder_sva.sv ====
// timing checks on the prefix decoder ports
// assumes it is bound to the decoder top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module prefix_code_decoder_sva (
	input wire logic                             core_clk,       // core clock
	input wire logic                             reset_n,        // async reset
	input wire logic                             issue,          // issue strobe
	input wire prefix_code_pkg::instr_class_type instrClass,     // issued class
	input wire logic                             intAccept,      // irq accepted
	input wire prefix_code_pkg::space_type       dataSpace,      // chosen space
	input wire logic                             flagUpdateEn,   // flags writable
	input wire logic                             intSampleEn,    // irq sampling
	input wire logic                             stackSelect,    // stack flag
	input wire logic                             decodeValid     // result strobe
);
	import prefix_code_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire logic go = issue; // issue strobe alias
	property p_valid; go |=> decodeValid ##1 (decodeValid == $past(go)); endproperty
	a_valid: assert property (p_valid) else $error("result strobe mistimed");
	property p_gate; go && instrClass inside {[CLS_CODE_PFX:CLS_STATUS_POP]} |=> !intSampleEn;
	endproperty
	a_gate: assert property (p_gate) else $error("sampling open after disable op");
	property p_open; go && instrClass == CLS_PLAIN |=> intSampleEn; endproperty
	a_open: assert property (p_open) else $error("sampling shut after plain op");
	property p_str; go && instrClass == CLS_STRING |=> dataSpace == SPACE_OPERAND; endproperty
	a_str: assert property (p_str) else $error("string space wrong");
	property p_io; go && instrClass == CLS_IO |=> dataSpace == SPACE_IO; endproperty
	a_io: assert property (p_io) else $error("io space wrong");
	property p_return_from_interrupt; go && instrClass == CLS_RETURN_INT |=> dataSpace == SPACE_SYS_STACK;
	endproperty
	a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return stack wrong");
	property p_stk; go && instrClass == CLS_STACK_OP && !intAccept |=>
		dataSpace == ($past(stackSelect) ? SPACE_SYS_STACK : SPACE_USER_STACK); endproperty
	a_stk: assert property (p_stk) else $error("stack op space wrong");
	property p_flg; go && instrClass inside {CLS_SOFT_INT, CLS_RETURN_INT, CLS_CTX_JUMP}
		|=> flagUpdateEn; endproperty
	a_flg: assert property (p_flg) else $error("flag update suppressed");
	property p_acc; intAccept |=> stackSelect; endproperty
	a_acc: assert property (p_acc) else $error("stack flag not set");
endmodule // prefix_code_decoder_sva
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the prefix decoder
// assumes the fetch model and the bound checker beside it
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import prefix_code_pkg::*;
	logic core_clk = 1'h0; // 50 MHz
	logic reset_n = 1'h0; // held low at start
	logic intAccept = 1'h0, stackFlagWrite = 1'h0, stackFlagData = 1'h0; // side inputs
	logic [4:0] rbp = 5'h0a; // bank pointer
	logic issue, resumeString, fu, ise, ss, dv; // design signals
	instr_class_type cls; // issued class
	space_type ds; // space seen
	logic [4:0] bpu; // pointer seen
	int n_mismatch = 0, total_checks = 0, cycles = 0; // tallies
	always #10 core_clk = ~core_clk;
	fetch_model u_fetch (.clk(core_clk), .instrClass(cls), .issue(issue),
		.resumeString(resumeString));
	prefix_code_decoder uut (.core_clk(core_clk), .reset_n(reset_n), .issue(issue),
		.instrClass(cls), .resumeString(resumeString), .intAccept(intAccept),
		.stackFlagWrite(stackFlagWrite), .stackFlagData(stackFlagData),
		.regBankPointer(rbp), .dataSpace(ds), .bankPtrUsed(bpu), .flagUpdateEn(fu),
		.intSampleEn(ise), .stackSelect(ss), .decodeValid(dv));
	task automatic tally_and_finish();
		if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic t_last(); // conflicting bank prefixes
		u_fetch.go(CLS_CODE_PFX); chk(ise, 0);
		u_fetch.go(CLS_EXTRA_PFX); u_fetch.go(CLS_PLAIN); chk(ds, SPACE_EXTRA);
		chk(ise, 1);
		u_fetch.go(CLS_STACK_PFX); u_fetch.go(CLS_DATA_PFX); u_fetch.go(CLS_PLAIN);
		chk(ds, SPACE_DATA);
		u_fetch.go(CLS_PLAIN); chk(ds, SPACE_DEFAULT);
		u_fetch.go(CLS_CODE_PFX); u_fetch.go(CLS_STACK_PFX); u_fetch.go(CLS_PLAIN);
		chk(ds, SPACE_SYS_STACK);
	endtask
	task automatic t_carry(); // prefix across disable ops
		u_fetch.go(CLS_DATA_PFX); u_fetch.go(CLS_CCR_LOGIC); u_fetch.go(CLS_ILM_LOAD);
		u_fetch.go(CLS_STATUS_POP); chk(ise, 0);
		u_fetch.go(CLS_PLAIN); chk(ds, SPACE_DATA);
	endtask
	task automatic t_except(); // prefix-immune classes
		instr_class_type c[4] = '{CLS_STRING, CLS_IO, CLS_RETURN_INT, CLS_STACK_OP};
		space_type e[4] = '{SPACE_OPERAND, SPACE_IO, SPACE_SYS_STACK, SPACE_SYS_STACK};
		for (int i = 0; i < 4; i++) begin
			u_fetch.go(CLS_DATA_PFX); u_fetch.go(c[i]); chk(ds, e[i]);
		end
	endtask
	task automatic t_shared(); // shared bank then freeze
		u_fetch.go(CLS_SHARED_PFX); u_fetch.go(CLS_PLAIN); chk(bpu, 5'h00);
		u_fetch.go(CLS_PLAIN); chk(bpu, 5'h0a);
		u_fetch.go(CLS_FREEZE_PFX); u_fetch.go(CLS_PLAIN); chk(fu, 0);
		u_fetch.go(CLS_FREEZE_PFX); u_fetch.go(CLS_CTX_JUMP); chk(fu, 1);
		u_fetch.go(CLS_FREEZE_PFX); u_fetch.go(CLS_SOFT_INT); chk(fu, 1);
		u_fetch.idle();
	endtask
	task automatic t_stack(); // stack flag write and accept
		stackFlagWrite = 1'h1;
		@(posedge core_clk); #1;
		stackFlagWrite = 1'h0;
		@(posedge core_clk); #1;
		chk(ss, 0);
		u_fetch.go(CLS_STACK_PFX); u_fetch.go(CLS_PLAIN); chk(ds, SPACE_USER_STACK);
		u_fetch.go(CLS_STACK_OP); chk(ds, SPACE_USER_STACK);
		u_fetch.idle();
		intAccept = 1'h1;
		@(posedge core_clk); #1;
		intAccept = 1'h0;
		@(posedge core_clk); #1;
		chk(ss, 1);
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		#1 reset_n = 1'h1;
		repeat (3) @(posedge core_clk);
		#1;
		chk(ss, 1);
		t_last(); t_carry(); t_except(); t_shared(); t_stack();
		tally_and_finish();
	end
endmodule // tb_top
bind prefix_code_decoder prefix_code_decoder_sva u_sva (.core_clk(core_clk),
	.reset_n(reset_n), .issue(issue), .instrClass(instrClass), .intAccept(intAccept),
	.dataSpace(dataSpace), .flagUpdateEn(flagUpdateEn), .intSampleEn(intSampleEn),
	.stackSelect(stackSelect), .decodeValid(decodeValid));
`default_nettype wire
